// [inc/cae_params.svh]
// constants for the channel alarm evaluator
`ifndef CAE_PARAMS_SVH
`define CAE_PARAMS_SVH
`define CAE_NUM_ALARMS 6
`define CAE_VAL_W 16
`define CAE_DIG_W 8
`define CAE_RELAY_W 8
`define CAE_TIME_W 16
`define CAE_PCT_W 8
`define CAE_CLK_NS 40
`define CAE_SEC_NS 1000000000
`define CAE_SEC_CYCLES (`CAE_SEC_NS / `CAE_CLK_NS)
`define CAE_DAMP_MIN_S 1
`define CAE_DAMP_MAX_S 64800
`define CAE_PCT_FULL 100
`define CAE_EN_OFF 2'h0
`define CAE_EN_ALWAYS 2'h1
`define CAE_EN_DIG 2'h2
`define CAE_TY_HIGH 3'h0
`define CAE_TY_LOW 3'h1
`define CAE_TY_DEV 3'h2
`define CAE_TY_RUP 3'h3
`define CAE_TY_RDN 3'h4
`endif

// [inc/cae_pkg.sv]
// types for the channel alarm evaluator
package cae_pkg;
    typedef logic [1:0] cae_en_t;
    typedef logic [2:0] cae_type_t;
    typedef enum logic [1:0] {ALM_IDLE, ALM_DAMP, ALM_ACTIVE} cae_phase_e;
endpackage : cae_pkg

// [rtl/cae_alarm_evaluator.sv]
// alarm evaluator for one measurement channel with up to six alarms
`timescale 1ns/1ps
`include "cae_params.svh"
// Operation
// [RULE1] up to six alarms, each separately configured
// [RULE2] enable is off, always, or digital gated
// [RULE3] gated alarm evaluated only while inputs permit
// [RULE4] high above level, low below level
// [RULE5] deviation beyond amount from reference value
// [RULE6] rate alarms on rise or fall percentage
// [RULE7] rate window counted in seconds
// [RULE8] selected relays driven while alarm active
// [RULE9] latched clears only after release and acknowledge; the code also clears a latched alarm at once when its enable drops
// [RULE10] alarm logging rate while log-change alarm active
// [RULE11] chart mark pulse when alarm activates
// [RULE12] hysteresis span percentage delays release, not deviation
// [RULE13] damping delays entry, one to 64800 seconds
// [RULE14] reflash re-raises unacknowledged after reflash time
// [RULE15] notification request when any alarm activates
// [RULE16] evaluate per sample tick, one-second prescaler
module cae_alarm_evaluator #(
    parameter int NUM_ALARMS = `CAE_NUM_ALARMS,
    parameter int VAL_W = `CAE_VAL_W,
    parameter int DIG_W = `CAE_DIG_W,
    parameter int RELAY_W = `CAE_RELAY_W,
    parameter int SEC_CYCLES = `CAE_SEC_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_tick,
    input wire logic signed [VAL_W-1:0] chan_value,
    input wire logic [VAL_W-1:0] scale_span,
    input wire logic [DIG_W-1:0] dig_in,
    input wire logic [NUM_ALARMS-1:0] ack,
    input wire logic notify_en,
    input wire logic [2*NUM_ALARMS-1:0] en_mode,
    input wire logic [DIG_W*NUM_ALARMS-1:0] dig_sel,
    input wire logic [3*NUM_ALARMS-1:0] alarm_type,
    input wire logic [VAL_W*NUM_ALARMS-1:0] level,
    input wire logic [VAL_W*NUM_ALARMS-1:0] ref_value,
    input wire logic [VAL_W*NUM_ALARMS-1:0] dev_level,
    input wire logic [`CAE_TIME_W*NUM_ALARMS-1:0] rate_period,
    input wire logic [RELAY_W*NUM_ALARMS-1:0] relay_sel,
    input wire logic [NUM_ALARMS-1:0] latch_en,
    input wire logic [NUM_ALARMS-1:0] log_en,
    input wire logic [NUM_ALARMS-1:0] mark_en,
    input wire logic [NUM_ALARMS-1:0] hyst_en,
    input wire logic [`CAE_PCT_W*NUM_ALARMS-1:0] hyst_pct,
    input wire logic [NUM_ALARMS-1:0] damp_en,
    input wire logic [`CAE_TIME_W*NUM_ALARMS-1:0] damp_time,
    input wire logic [NUM_ALARMS-1:0] reflash_en,
    input wire logic [`CAE_TIME_W*NUM_ALARMS-1:0] reflash_time,
    output logic [NUM_ALARMS-1:0] alarm_active,
    output logic [NUM_ALARMS-1:0] alarm_unacked,
    output logic [NUM_ALARMS-1:0] chart_mark,
    output logic [RELAY_W-1:0] relay_out,
    output logic log_alarm_rate,
    output logic notify_req
);
    localparam int TW = `CAE_TIME_W;
    localparam int PW = `CAE_PCT_W;
    localparam int SW = VAL_W + 2;
    localparam int CW = $clog2(SEC_CYCLES + 1);

    if (NUM_ALARMS < 1 || NUM_ALARMS > `CAE_NUM_ALARMS) begin : g_chk_n
        $error("NUM_ALARMS must be 1 to 6");
    end
    if (SEC_CYCLES < 1) begin : g_chk_s
        $error("SEC_CYCLES must be at least 1");
    end

    // scale span times percent over one hundred
    function automatic logic signed [SW-1:0] pct_amt(
        input logic [VAL_W-1:0] span,
        input logic [PW-1:0] pct
    );
        logic [VAL_W+PW-1:0] p;
        begin
            p = (VAL_W+PW)'(span) * (VAL_W+PW)'(pct);
            pct_amt = $signed(SW'(p / (VAL_W+PW)'(`CAE_PCT_FULL)));
        end
    endfunction : pct_amt

    logic rst_s1_ff;
    logic rst_s2_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    wire rst_sync_n = rst_s2_ff;

    logic [DIG_W-1:0] dig_s1_ff;
    logic [DIG_W-1:0] dig_s2_ff;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dig_s1_ff <= '0;
            dig_s2_ff <= '0;
        end else begin
            dig_s1_ff <= dig_in;
            dig_s2_ff <= dig_s1_ff;
        end
    end

    // one-second prescaler; a second is held until the next sample tick
    logic [CW-1:0] pre_ff;
    logic sec_pend_ff;
    wire sec_now = (pre_ff == CW'(SEC_CYCLES - 1)); // RULE16
    wire [CW-1:0] nxt_pre = sec_now ? '0 : pre_ff + CW'(1);
    wire nxt_sec_pend = sec_now | (sec_pend_ff & ~sample_tick);
    wire sec = sample_tick & (sec_pend_ff | sec_now); // RULE16
    logic [NUM_ALARMS-1:0] ack_pend_ff;
    wire [NUM_ALARMS-1:0] nxt_ack_pend = ack |
        (ack_pend_ff & {NUM_ALARMS{~sample_tick}});
    wire [NUM_ALARMS-1:0] ackd = ack | ack_pend_ff;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pre_ff <= '0;
            sec_pend_ff <= 1'b0;
            ack_pend_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
            sec_pend_ff <= nxt_sec_pend;
            ack_pend_ff <= nxt_ack_pend;
        end
    end

    cae_pkg::cae_phase_e phase_ff [NUM_ALARMS];
    logic [NUM_ALARMS-1:0] trig_ff;
    logic [NUM_ALARMS-1:0] nxt_active;
    logic [NUM_ALARMS-1:0] nxt_unack;
    logic [NUM_ALARMS-1:0] rise;
    wire signed [SW-1:0] v = SW'(chan_value);

    for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alm // RULE1
        wire cae_pkg::cae_en_t mode = en_mode[2*g +: 2];
        wire cae_pkg::cae_type_t ty = alarm_type[3*g +: 3];
        wire signed [SW-1:0] lvl = SW'($signed(level[VAL_W*g +: VAL_W]));
        wire signed [SW-1:0] rf = SW'($signed(ref_value[VAL_W*g +: VAL_W]));
        wire signed [SW-1:0] dev = SW'($signed(dev_level[VAL_W*g +: VAL_W]));
        wire [TW-1:0] per = rate_period[TW*g +: TW];
        wire [TW-1:0] dtm = damp_time[TW*g +: TW];
        wire [TW-1:0] rtm = reflash_time[TW*g +: TW];
        wire gate = |(dig_sel[DIG_W*g +: DIG_W] & dig_s2_ff);
        wire en = (mode == `CAE_EN_ALWAYS) ||
            ((mode == `CAE_EN_DIG) && gate); // RULE2 RULE3
        wire signed [SW-1:0] hy = (hyst_en[g] && ty != `CAE_TY_DEV) ?
            pct_amt(scale_span, hyst_pct[PW*g +: PW]) : '0; // RULE12
        wire signed [SW-1:0] rthr =
            pct_amt(scale_span, dev_level[VAL_W*g +: PW]);
        wire signed [SW-1:0] dref = v - rf;
        wire signed [SW-1:0] adref = dref[SW-1] ? -dref : dref;

        logic signed [SW-1:0] base_ff;
        logic [TW-1:0] win_ff;
        logic [TW-1:0] dcnt_ff;
        logic [TW-1:0] rcnt_ff;
        logic act_ff;
        logic unack_ff;
        wire signed [SW-1:0] rd = v - base_ff;
        wire signed [SW-1:0] nrd = base_ff - v;
        logic c_set;
        logic c_hold;
        always_comb begin
            c_set = 1'b0;
            c_hold = 1'b0;
            case (ty)
                `CAE_TY_HIGH: begin // RULE4
                    c_set = v > lvl;
                    c_hold = v > lvl - hy; // RULE12
                end
                `CAE_TY_LOW: begin // RULE4
                    c_set = v < lvl;
                    c_hold = v < lvl + hy; // RULE12
                end
                `CAE_TY_DEV: begin // RULE5
                    c_set = adref > dev;
                    c_hold = adref > dev;
                end
                `CAE_TY_RUP: begin // RULE6
                    c_set = rd > rthr;
                    c_hold = rd > rthr - hy;
                end
                `CAE_TY_RDN: begin // RULE6
                    c_set = nrd > rthr;
                    c_hold = nrd > rthr - hy;
                end
                default: begin
                    c_set = 1'b0;
                    c_hold = 1'b0;
                end
            endcase
        end
        wire nxt_trig = en & (trig_ff[g] ? c_hold : c_set);
        wire win_done = sec && (win_ff + TW'(1) >= per); // RULE7
        wire damp_done = sec && (dcnt_ff + TW'(1) >= dtm); // RULE13
        wire refl_done = sec && (rcnt_ff + TW'(1) >= rtm); // RULE14

        cae_pkg::cae_phase_e nxt_phase;
        logic [TW-1:0] nxt_dcnt;
        logic [TW-1:0] nxt_rcnt;
        logic go;
        logic un;
        always_comb begin
            nxt_phase = phase_ff[g];
            nxt_dcnt = dcnt_ff;
            nxt_rcnt = rcnt_ff;
            go = 1'b0;
            un = unack_ff;
            case (phase_ff[g])
                cae_pkg::ALM_IDLE: begin
                    nxt_dcnt = '0;
                    if (nxt_trig && damp_en[g]) begin
                        nxt_phase = cae_pkg::ALM_DAMP;
                    end else if (nxt_trig) begin
                        go = 1'b1;
                    end
                end
                cae_pkg::ALM_DAMP: begin // RULE13
                    if (!nxt_trig) begin
                        nxt_phase = cae_pkg::ALM_IDLE;
                    end else if (damp_done) begin
                        go = 1'b1;
                    end else if (sec) begin
                        nxt_dcnt = dcnt_ff + TW'(1);
                    end
                end
                cae_pkg::ALM_ACTIVE: begin
                    if (ackd[g]) begin
                        un = 1'b0;
                        nxt_rcnt = '0;
                    end else if (reflash_en[g] && !unack_ff && nxt_trig) begin
                        nxt_rcnt = refl_done ? '0 : rcnt_ff + TW'(sec);
                        un = refl_done; // RULE14
                    end
                    if (!nxt_trig && (!latch_en[g] || !un)) begin // RULE9
                        nxt_phase = cae_pkg::ALM_IDLE;
                        un = 1'b0;
                    end
                end
                default: nxt_phase = cae_pkg::ALM_IDLE;
            endcase
            if (go) begin
                nxt_phase = cae_pkg::ALM_ACTIVE;
                nxt_rcnt = '0;
                un = 1'b1;
            end
            if (!en) begin // RULE3
                nxt_phase = cae_pkg::ALM_IDLE;
                un = 1'b0;
                go = 1'b0;
            end
        end
        assign nxt_active[g] = sample_tick ?
            (nxt_phase == cae_pkg::ALM_ACTIVE) : act_ff;
        assign nxt_unack[g] = sample_tick ? un : unack_ff;
        assign rise[g] = sample_tick & go;
        assign alarm_active[g] = act_ff;
        assign alarm_unacked[g] = unack_ff;

        always_ff @(posedge clock or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                phase_ff[g] <= cae_pkg::ALM_IDLE;
                trig_ff[g] <= 1'b0;
                dcnt_ff <= '0;
                rcnt_ff <= '0;
                act_ff <= 1'b0;
                unack_ff <= 1'b0;
            end else if (sample_tick) begin // RULE16
                phase_ff[g] <= nxt_phase;
                trig_ff[g] <= nxt_trig;
                dcnt_ff <= nxt_dcnt;
                rcnt_ff <= nxt_rcnt;
                act_ff <= nxt_active[g];
                unack_ff <= nxt_unack[g];
            end
        end

        // rate window rebases on the current value each time it ends
        always_ff @(posedge clock or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                base_ff <= '0;
                win_ff <= '0;
            end else if (sample_tick && (!en || win_done)) begin
                base_ff <= v; // RULE7
                win_ff <= '0;
            end else if (sec) begin
                win_ff <= win_ff + TW'(1);
            end
        end
    end

    logic [RELAY_W-1:0] nxt_relay;
    logic nxt_log;
    always_comb begin
        nxt_relay = '0;
        nxt_log = 1'b0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (nxt_active[i]) begin
                nxt_relay = nxt_relay | relay_sel[RELAY_W*i +: RELAY_W];
                nxt_log = nxt_log | log_en[i];
            end
        end
    end

    logic [RELAY_W-1:0] relay_ff;
    logic log_ff;
    logic [NUM_ALARMS-1:0] mark_ff;
    logic notify_ff;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            relay_ff <= '0;
            log_ff <= 1'b0;
            mark_ff <= '0;
            notify_ff <= 1'b0;
        end else begin
            relay_ff <= nxt_relay; // RULE8
            log_ff <= nxt_log; // RULE10
            mark_ff <= rise & mark_en; // RULE11
            notify_ff <= notify_en & (|rise); // RULE15
        end
    end
    assign relay_out = relay_ff;
    assign log_alarm_rate = log_ff;
    assign chart_mark = mark_ff;
    assign notify_req = notify_ff;
endmodule : cae_alarm_evaluator

// [sim/cae_alarm_checker.sv]
// port assertions for the channel alarm evaluator
`timescale 1ns/1ps
module cae_alarm_checker #(
    parameter int NUM_ALARMS = 6,
    parameter int VAL_W = 16,
    parameter int RELAY_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_tick,
    input wire logic signed [VAL_W-1:0] chan_value,
    input wire logic [NUM_ALARMS-1:0] ack,
    input wire logic [2*NUM_ALARMS-1:0] en_mode,
    input wire logic [3*NUM_ALARMS-1:0] alarm_type,
    input wire logic [VAL_W*NUM_ALARMS-1:0] level,
    input wire logic [RELAY_W*NUM_ALARMS-1:0] relay_sel,
    input wire logic [NUM_ALARMS-1:0] latch_en,
    input wire logic [NUM_ALARMS-1:0] log_en,
    input wire logic [NUM_ALARMS-1:0] hyst_en,
    input wire logic [NUM_ALARMS-1:0] damp_en,
    input wire logic [NUM_ALARMS-1:0] alarm_active,
    input wire logic [NUM_ALARMS-1:0] alarm_unacked,
    input wire logic [NUM_ALARMS-1:0] chart_mark,
    input wire logic [RELAY_W-1:0] relay_out,
    input wire logic log_alarm_rate,
    input wire logic notify_req
);
    logic [RELAY_W*NUM_ALARMS-1:0] sel_ff;
    logic [NUM_ALARMS-1:0] log_ff;
    logic ack_ff;
    logic [RELAY_W-1:0] relay_exp;
    logic [NUM_ALARMS-1:0] off_v;
    wire logic signed [VAL_W-1:0] lvl0 = level[VAL_W-1:0];
    wire logic hi0 = en_mode[1:0] == 2'h1 && alarm_type[2:0] == 3'h0;
    always_comb begin
        relay_exp = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            off_v[i] = en_mode[2*i+:2] == 2'h0 || en_mode[2*i+:2] == 2'h3;
            if (alarm_active[i]) relay_exp |= sel_ff[RELAY_W*i+:RELAY_W];
        end
    end
    // ack seen for alarm 0 since the last tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= '0;
            log_ff <= '0;
            ack_ff <= 1'b0;
        end else begin
            sel_ff <= relay_sel;
            log_ff <= log_en;
            ack_ff <= !sample_tick && (ack_ff || ack[0]);
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    AST_TICK_ONLY: assert property (!sample_tick |=>
        $stable(alarm_active) && $stable(relay_out)) else $error("moved");
    AST_RELAY_OR: assert property ($past(sample_tick) |->
        relay_out == relay_exp) else $error("relay mismatch");
    AST_LOG_RATE: assert property ($past(sample_tick) |->
        log_alarm_rate == |(alarm_active & log_ff)) else $error("log rate");
    AST_MARK_RISE: assert property (chart_mark != '0 |->
        (chart_mark & ~(alarm_active & ~$past(alarm_active))) == '0)
        else $error("mark without activation");
    AST_MARK_PULSE: assert property (chart_mark[0] |=>
        !chart_mark[0]) else $error("mark too long");
    AST_NOTIFY_RISE: assert property (notify_req |->
        (alarm_active & ~$past(alarm_active)) != '0) else $error("notify");
    AST_OFF_IDLE: assert property (sample_tick |=>
        (alarm_active & $past(off_v)) == '0) else $error("disabled active");
    AST_UNACK_ACTIVE: assert property (
        (alarm_unacked & ~alarm_active) == '0) else $error("unacked idle");
    AST_HIGH_ENTER: assert property (sample_tick && hi0 &&
        !damp_en[0] && chan_value > lvl0 |=> alarm_active[0])
        else $error("high not raised");
    AST_HIGH_LEAVE: assert property (sample_tick && hi0 &&
        !latch_en[0] && !hyst_en[0] && chan_value <= lvl0 |=>
        !alarm_active[0]) else $error("high not released");
    AST_LATCH_HOLD: assert property (sample_tick && alarm_active[0] &&
        alarm_unacked[0] && latch_en[0] && en_mode[1:0] == 2'h1 &&
        !ack_ff && !ack[0] |=> alarm_active[0])
        else $error("latched alarm dropped");
endmodule : cae_alarm_checker
bind cae_alarm_evaluator cae_alarm_checker #(.NUM_ALARMS(NUM_ALARMS),
    .VAL_W(VAL_W), .RELAY_W(RELAY_W)) chk_i (.clock, .rst_n, .sample_tick,
    .chan_value, .ack, .en_mode, .alarm_type, .level, .relay_sel, .latch_en,
    .log_en, .hyst_en, .damp_en, .alarm_active, .alarm_unacked, .chart_mark,
    .relay_out, .log_alarm_rate, .notify_req);

// [sim/cae_chan_src.sv]
// acquisition side model: periodic sample ticks with channel values
`timescale 1ns/1ps
module cae_chan_src (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] gap,
    input wire logic signed [15:0] value_in,
    output logic sample_tick,
    output logic signed [15:0] chan_value
);
    logic [3:0] cnt_ff;
    // gap 0 gives back-to-back ticks; first tick comes late enough after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            sample_tick <= 1'b0;
            chan_value <= 16'h0000;
        end else begin
            cnt_ff <= (cnt_ff >= gap) ? 4'h0 : cnt_ff + 4'h1;
            sample_tick <= cnt_ff == gap;
            chan_value <= value_in;
        end
    end
endmodule : cae_chan_src

// [sim/tb_top.sv]
// self-checking bench for the channel alarm evaluator
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [2:0] ty; logic [1:0] md; logic [7:0] din;
        logic [15:0] v; logic x;} cae_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] gap = 4'h3;
    logic signed [15:0] val = 16'h0000;
    logic signed [15:0] chan_value;
    logic sample_tick, log_alarm_rate, notify_req;
    logic notify_en = 1'b1;
    logic [15:0] scale_span = 16'h03e8;
    logic [7:0] dig_in = 8'h00;
    logic [7:0] relay_out;
    logic [5:0] ack = 6'h00, latch_en = 6'h00, log_en = 6'h01;
    logic [5:0] mark_en = 6'h3f, hyst_en = 6'h00, damp_en = 6'h00;
    logic [5:0] reflash_en = 6'h00, alarm_active, alarm_unacked, chart_mark;
    logic [11:0] en_mode = 12'h000;
    logic [17:0] alarm_type = 18'h00000;
    logic [47:0] dig_sel = {6{8'h01}}, hyst_pct = {6{8'h0a}};
    logic [47:0] relay_sel = 48'h300000000005;
    logic [95:0] level = {6{16'h0064}}, ref_value = {6{16'h0032}};
    logic [95:0] dev_level = {6{16'h000a}}, rate_period = {6{16'h003c}};
    logic [95:0] damp_time = {6{16'h0003}}, reflash_time = {6{16'h0002}};
    int fail_count = 0, n_checks = 0, marks, nots;
    cae_row_s rows[16] = '{
        '{3'h0, 2'h1, 8'h00, 16'h0065, 1'b1},
        '{3'h0, 2'h1, 8'h00, 16'h0064, 1'b0},
        '{3'h1, 2'h1, 8'h00, 16'h0063, 1'b1},
        '{3'h1, 2'h1, 8'h00, 16'h0064, 1'b0},
        '{3'h2, 2'h1, 8'h00, 16'h003d, 1'b1},
        '{3'h2, 2'h1, 8'h00, 16'h003c, 1'b0},
        '{3'h2, 2'h1, 8'h00, 16'h0027, 1'b1},
        '{3'h0, 2'h0, 8'h00, 16'h00c8, 1'b0},
        '{3'h0, 2'h3, 8'h00, 16'h00c8, 1'b0},
        '{3'h0, 2'h2, 8'h00, 16'h00c8, 1'b0},
        '{3'h0, 2'h2, 8'h01, 16'h00c8, 1'b1},
        '{3'h0, 2'h0, 8'h00, 16'h0000, 1'b0},
        '{3'h3, 2'h1, 8'h00, 16'h00c8, 1'b1},
        '{3'h0, 2'h0, 8'h00, 16'h0000, 1'b0},
        '{3'h4, 2'h1, 8'h00, 16'hff38, 1'b1},
        '{3'h0, 2'h1, 8'h00, 16'h0000, 1'b0}};
    cae_chan_src src (.clock, .rst_n, .gap, .value_in(val), .sample_tick,
        .chan_value);
    cae_alarm_evaluator #(.SEC_CYCLES(10)) DUT (.clock, .rst_n, .sample_tick,
        .chan_value, .scale_span, .dig_in, .ack, .notify_en, .en_mode,
        .dig_sel, .alarm_type, .level, .ref_value, .dev_level, .rate_period,
        .relay_sel, .latch_en, .log_en, .mark_en, .hyst_en, .hyst_pct,
        .damp_en, .damp_time, .reflash_en, .reflash_time, .alarm_active,
        .alarm_unacked, .chart_mark, .relay_out, .log_alarm_rate, .notify_req);
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk
    // wait for k ticks, counting alarm 0 mark and notify pulses meanwhile
    task automatic ticks(input int k);
        int n = 0;
        marks = 0;
        nots = 0;
        while (k > 0) begin
            @(posedge clock);
            if (sample_tick === 1'b1) k--;
            #1;
            marks += int'(chart_mark[0] === 1'b1);
            nots += int'(notify_req === 1'b1);
            n++;
            if (n > 100) begin
                $display("ERROR tick_wait expected %0d seen %0d", 100, n);
                fail_count++;
                print_verdict();
            end
        end
    endtask : ticks
    task automatic setv(input logic [15:0] v, input int k);
        @(posedge clock);
        val <= v;
        ticks(k);
    endtask : setv
    task automatic ack0();
        @(posedge clock);
        ack <= 6'h01;
        @(posedge clock);
        ack <= 6'h00;
    endtask : ack0
    initial begin
        repeat (8) @(posedge clock);
        chk("reset_relay", 8'h00, relay_out);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clock);
            alarm_type[2:0] <= rows[i].ty;
            en_mode[1:0] <= rows[i].md;
            dig_in <= rows[i].din;
            // config and value change on one edge so every rise is counted
            val <= rows[i].v;
            ticks(3);
            chk("active", 8'(rows[i].x), 8'(alarm_active[0]));
            chk("relay", rows[i].x ? 8'h05 : 8'h00, relay_out);
            chk("lograte", 8'(rows[i].x), 8'(log_alarm_rate));
            chk("mark", 8'(rows[i].x), 8'(marks));
            chk("notify", 8'(rows[i].x), 8'(nots));
        end
        @(posedge clock);
        latch_en <= 6'h01;
        en_mode <= 12'h401;
        setv(16'h00c8, 3);
        chk("relay_or", 8'h35, relay_out);
        chk("multi", 8'h21, 8'(alarm_active));
        setv(16'h0000, 3);
        chk("latched", 8'h01, 8'(alarm_active));
        ack0();
        ticks(2);
        chk("release", 8'h00, 8'(alarm_active));
        // an ack taken while the condition holds counts at its release
        setv(16'h00c8, 3);
        ack0();
        ticks(2);
        chk("acked", 8'h20, 8'(alarm_unacked));
        chk("ack_hold", 8'h21, 8'(alarm_active));
        setv(16'h0000, 3);
        chk("ack_first", 8'h00, 8'(alarm_active));
        @(posedge clock);
        latch_en <= 6'h00;
        hyst_en <= 6'h01;
        mark_en <= 6'h00;
        notify_en <= 1'b0;
        gap <= 4'h0;
        setv(16'h00c8, 3);
        chk("mark_off", 8'h00, 8'(marks));
        chk("notify_off", 8'h00, 8'(nots));
        setv(16'h0032, 3);
        chk("hyst_hold", 8'h01, 8'(alarm_active[0]));
        setv(16'h0000, 3);
        chk("hyst_off", 8'h00, 8'(alarm_active[0]));
        @(posedge clock);
        hyst_en <= 6'h00;
        damp_en <= 6'h01;
        mark_en <= 6'h3f;
        notify_en <= 1'b1;
        gap <= 4'h3;
        setv(16'h00c8, 2);
        chk("damp_wait", 8'h00, 8'(alarm_active[0]));
        ticks(10);
        chk("damp_on", 8'h01, 8'(alarm_active[0]));
        chk("damp_mark", 8'h01, 8'(marks));
        @(posedge clock);
        reflash_en <= 6'h01;
        ack0();
        ticks(1);
        chk("ack_now", 8'h00, 8'(alarm_unacked[0]));
        ticks(12);
        chk("reflash", 8'h01, 8'(alarm_unacked[0]));
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        #1;
        chk("mid_reset", 8'h00, 8'(alarm_active));
        print_verdict();
    end
endmodule : tb_top
